/* pkg/remote_cmd_pkg.sv */
// Purpose: Constants and carriers for the remote key command interpreter.
// Assumes: ASCII characters arrive and leave as 8-bit bytes from a UART.
// Notes: Reply texts are supplied by the display core as fixed-width character vectors.
package remote_cmd_pkg;
   localparam logic [7:0] CH_ESC = 8'h1B;
   localparam logic [7:0] CH_CR = 8'h0D;
   localparam logic [7:0] CH_LF = 8'h0A;
   localparam logic [7:0] CH_ACK = 8'h06;
   localparam logic [7:0] CH_NAK = 8'h15;
   localparam logic [7:0] CH_STX = 8'h02;
   localparam logic [7:0] CH_XON = 8'h11;
   localparam logic [7:0] CH_XOFF = 8'h13;
   localparam logic [7:0] CH_ZERO = 8'h30;
   localparam logic [7:0] CH_NINE = 8'h39;
   localparam logic [7:0] CLS_KEY = 8'h54;
   localparam logic [7:0] CLS_SCREEN = 8'h41;
   localparam logic [7:0] CLS_FUNC = 8'h46;
   localparam logic [7:0] CLS_SPECIAL = 8'h53;
   localparam int BUF_DEPTH = 100;
   localparam int FRAME_LEN = 7;
   localparam int TEXT_MAX = 35;
   localparam int ID_LINES = 3;
   localparam int ID_LEN = 10;
   localparam int POS_MAX = 13;
   localparam int SBAR_LEN = 8;
   localparam int SIND_LEN = 10;
   localparam logic [13:0] KEY_DIGIT_MAX = 14'h0009;
   localparam logic [13:0] KEY_CLEAR = 14'h0064;
   localparam logic [13:0] KEY_LAST = 14'h006E;
   localparam logic [13:0] SCR_IDENT = 14'h0000;
   localparam logic [13:0] SCR_DISPLAY = 14'h0064;
   localparam logic [13:0] SCR_ACTUAL = 14'h00C8;
   localparam logic [13:0] SCR_ERROR = 14'h012D;
   localparam logic [13:0] SCR_SOFTID = 14'h0190;
   localparam logic [13:0] SCR_SBAR = 14'h0320;
   localparam logic [13:0] SCR_SIND = 14'h0384;
   localparam logic [13:0] FN_REF = 14'h0000;
   localparam logic [13:0] FN_SERIES = 14'h0001;
   localparam logic [13:0] FN_PRINT = 14'h0002;
   localparam logic [13:0] SF_RESET = 14'h0000;
   localparam logic [13:0] SF_LOCK = 14'h0001;
   localparam logic [13:0] SF_RELEASE = 14'h0002;

   // Byte stream in either direction.
   typedef struct packed {
      logic valid;
      logic [7:0] data;
   } byte_t;

   // Snapshot of display state used for screen replies.
   typedef struct packed {
      logic [ID_LINES*ID_LEN*8-1:0] ident;
      logic [POS_MAX*8-1:0] disp_pos;
      logic [3:0] disp_len;
      logic [ID_LEN*8-1:0] act_pos;
      logic err_shown;
      logic [TEXT_MAX*8-1:0] err_text;
      logic [ID_LEN*8-1:0] soft_id;
      logic [SBAR_LEN*4-1:0] sbar;
      logic [SIND_LEN*2-1:0] sind;
   } screen_t;

   // One-cycle action pulses toward the display core.
   typedef struct packed {
      logic key_valid;
      logic [4:0] key_code;
      logic ref_toggle;
      logic series_start;
      logic print;
      logic unit_reset;
   } action_t;
endpackage

/* hdl/remote_key_command_interpreter.sv */
// Purpose: Parse escape-framed remote commands and answer them over the UART byte stream.
// Assumes: One clock; rx bytes come from a UART in the same domain; tx_ready paces replies.
// Notes: Keypad lock output gates local keys in the display core.
`timescale 1ns/100ps
module remote_key_command_interpreter #(
   parameter int DEPTH = remote_cmd_pkg::BUF_DEPTH
) (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rst_n,
   // Received and transmitted bytes
   input wire remote_cmd_pkg::byte_t rx,
   input wire logic tx_ready,
   output remote_cmd_pkg::byte_t tx,
   // Display state and actions
   input wire remote_cmd_pkg::screen_t screen,
   output remote_cmd_pkg::action_t action,
   output logic keypad_locked,
   output logic measure_req
);
   typedef enum logic [2:0] {
      P_IDLE = 3'h0,
      P_CLASS = 3'h1,
      P_DIGIT = 3'h2,
      P_CR = 3'h3,
      P_EXEC = 3'h4,
      P_SEND = 3'h5
   } parse_t;

   localparam int PW = $clog2(DEPTH + 1);
   localparam int AW = $clog2(DEPTH);
   localparam int LW = 7;
   localparam logic [PW-1:0] FULL = PW'(DEPTH);

   // Character buffer.
   logic [7:0] mem [DEPTH];
   logic [AW-1:0] wr_q, rd_q;
   logic [PW-1:0] cnt_q;
   logic stopped_q, xoff_pend_q, xon_pend_q;
   logic push, pop;
   logic [7:0] cur;

   // Parser and reply state.
   parse_t st_q;
   logic [7:0] cls_q;
   logic [13:0] num_q;
   logic [2:0] dig_q;
   logic bad_q;
   logic [8*48-1:0] rep_q;
   logic [LW-1:0] rep_len_q, rep_idx_q;
   logic post_key_q;
   logic [4:0] post_code_q;

   function automatic logic [AW-1:0] inc(input logic [AW-1:0] p);
      inc = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
   endfunction

   // Reply of STX, the first n characters of a w-character field sent from its top byte, then CR LF.
   function automatic logic [8*48-1:0] frame(input logic [8*remote_cmd_pkg::TEXT_MAX-1:0] v, input int w,
                                             input int n);
      frame = '0;
      frame[7:0] = remote_cmd_pkg::CH_STX;
      for (int i = 0; i < remote_cmd_pkg::TEXT_MAX; i++) begin
         if (i < n) begin
            frame[8*(i+1) +: 8] = v[8*(w-1-i) +: 8];
         end
      end
      frame[8*(n+1) +: 16] = {remote_cmd_pkg::CH_LF, remote_cmd_pkg::CH_CR};
   endfunction

   function automatic logic [7:0] digit(input logic [3:0] v);
      digit = remote_cmd_pkg::CH_ZERO + {4'h0, v};
   endfunction

   assign push = rx.valid && cnt_q != FULL;
   assign pop = (st_q != P_EXEC) && (st_q != P_SEND) && cnt_q != '0;
   assign cur = mem[rd_q];

   ////////////////////////////////////////////////////////////////////////////////
   // Buffer.
   always_ff @(posedge ref_clk) begin
      if (push) begin
         mem[wr_q] <= rx.data;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         wr_q <= '0;
         rd_q <= '0;
         cnt_q <= '0;
      end else begin
         if (push) begin
            wr_q <= inc(wr_q);
         end
         if (pop) begin
            rd_q <= inc(rd_q);
         end
         cnt_q <= cnt_q + PW'(push) - PW'(pop);
      end
   end

   // Flow control: XOFF on full, XON after all commands are executed.
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         stopped_q <= 1'b0;
         xoff_pend_q <= 1'b0;
         xon_pend_q <= 1'b0;
      end else begin
         if (!stopped_q && cnt_q + PW'(push) == FULL) begin
            stopped_q <= 1'b1;
            xoff_pend_q <= 1'b1;
         end else if (stopped_q && !xoff_pend_q && cnt_q == '0 && st_q == P_IDLE) begin
            stopped_q <= 1'b0;
            xon_pend_q <= 1'b1;
         end
         if (tx_ready && !tx.valid) begin
            if (xoff_pend_q) begin
               xoff_pend_q <= 1'b0;
            end else if (xon_pend_q && !(st_q == P_SEND && rep_idx_q != rep_len_q)) begin
               xon_pend_q <= 1'b0;
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Framing parser.
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         st_q <= P_IDLE;
         cls_q <= '0;
         num_q <= '0;
         dig_q <= '0;
         bad_q <= 1'b0;
      end else begin
         case (st_q)
            P_IDLE: begin
               if (pop && cur == remote_cmd_pkg::CH_ESC) begin
                  st_q <= P_CLASS;
               end
            end
            P_CLASS: begin
               if (pop) begin
                  cls_q <= cur;
                  num_q <= '0;
                  dig_q <= '0;
                  bad_q <= 1'b0;
                  st_q <= (cur == remote_cmd_pkg::CH_ESC) ? P_CLASS : P_DIGIT;
               end
            end
            P_DIGIT: begin
               if (pop) begin
                  if (cur == remote_cmd_pkg::CH_ESC) begin
                     st_q <= P_CLASS;
                  end else begin
                     if (cur < remote_cmd_pkg::CH_ZERO || cur > remote_cmd_pkg::CH_NINE) begin
                        bad_q <= 1'b1;
                     end
                     num_q <= 14'(num_q * 10 + 14'(cur[3:0]));
                     dig_q <= dig_q + 1'b1;
                     if (dig_q == 3'd3) begin
                        st_q <= P_CR;
                     end
                  end
               end
            end
            P_CR: begin
               if (pop) begin
                  if (cur == remote_cmd_pkg::CH_CR) begin
                     st_q <= P_EXEC;
                  end else if (cur == remote_cmd_pkg::CH_ESC) begin
                     st_q <= P_CLASS;
                  end else begin
                     st_q <= P_IDLE;
                  end
               end
            end
            P_EXEC: begin
               st_q <= P_SEND;
            end
            P_SEND: begin
               if (rep_idx_q == rep_len_q && !tx.valid) begin
                  st_q <= P_IDLE;
               end
            end
            default: begin
               st_q <= P_IDLE;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Reply build, command decode and actions.
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         rep_q <= '0;
         rep_len_q <= '0;
         action <= '0;
         keypad_locked <= 1'b0;
         measure_req <= 1'b0;
         post_key_q <= 1'b0;
         post_code_q <= '0;
      end else begin
         action <= '0;
         measure_req <= 1'b0;
         if (post_key_q && rep_idx_q == rep_len_q && !tx.valid) begin
            post_key_q <= 1'b0;
            action.key_valid <= 1'b1;
            action.key_code <= post_code_q;
         end
         if (st_q == P_EXEC) begin
            rep_q <= '0;
            rep_q[7:0] <= remote_cmd_pkg::CH_NAK;
            rep_len_q <= LW'(1);
            if (!bad_q) begin
               case (cls_q)
                  remote_cmd_pkg::CLS_KEY: begin
                     if (num_q <= remote_cmd_pkg::KEY_DIGIT_MAX ||
                         (num_q >= remote_cmd_pkg::KEY_CLEAR && num_q <= remote_cmd_pkg::KEY_LAST)) begin
                        rep_q[7:0] <= remote_cmd_pkg::CH_ACK;
                        post_key_q <= 1'b1;
                        post_code_q <= (num_q <= remote_cmd_pkg::KEY_DIGIT_MAX) ? 5'(num_q) :
                                       5'(num_q - remote_cmd_pkg::KEY_CLEAR + 14'd10);
                     end
                  end
                  remote_cmd_pkg::CLS_SCREEN: begin
                     // Replies are laid out byte 0 first, each line closed by CR LF.
                     if (num_q == remote_cmd_pkg::SCR_IDENT) begin
                        rep_q[7:0] <= remote_cmd_pkg::CH_STX;
                        for (int l = 0; l < remote_cmd_pkg::ID_LINES; l++) begin
                           for (int i = 0; i < remote_cmd_pkg::ID_LEN; i++) begin
                              rep_q[8*(1+12*l+i) +: 8] <= screen.ident[8*(29-10*l-i) +: 8];
                           end
                           rep_q[8*(11+12*l) +: 16] <= {remote_cmd_pkg::CH_LF, remote_cmd_pkg::CH_CR};
                        end
                        rep_len_q <= LW'(37);
                     end else if (num_q == remote_cmd_pkg::SCR_DISPLAY) begin
                        rep_q <= frame(280'(screen.disp_pos), remote_cmd_pkg::POS_MAX,
                                       int'(screen.disp_len));
                        rep_len_q <= LW'(screen.disp_len) + LW'(3);
                     end else if (num_q == remote_cmd_pkg::SCR_ACTUAL) begin
                        rep_q <= frame(280'(screen.act_pos), remote_cmd_pkg::ID_LEN, remote_cmd_pkg::ID_LEN);
                        rep_len_q <= LW'(13);
                     end else if (num_q == remote_cmd_pkg::SCR_ERROR && screen.err_shown) begin
                        rep_q <= frame(screen.err_text, remote_cmd_pkg::TEXT_MAX, remote_cmd_pkg::TEXT_MAX);
                        rep_len_q <= LW'(38);
                     end else if (num_q == remote_cmd_pkg::SCR_SOFTID) begin
                        rep_q <= frame(280'(screen.soft_id), remote_cmd_pkg::ID_LEN, remote_cmd_pkg::ID_LEN);
                        rep_len_q <= LW'(13);
                     end else if (num_q == remote_cmd_pkg::SCR_SBAR) begin
                        rep_q[7:0] <= remote_cmd_pkg::CH_STX;
                        for (int i = 0; i < remote_cmd_pkg::SBAR_LEN; i++) begin
                           rep_q[8*(i+1) +: 8] <= digit(screen.sbar[4*i +: 4]);
                        end
                        rep_q[8*9 +: 16] <= {remote_cmd_pkg::CH_LF, remote_cmd_pkg::CH_CR};
                        rep_len_q <= LW'(11);
                     end else if (num_q == remote_cmd_pkg::SCR_SIND) begin
                        rep_q[7:0] <= remote_cmd_pkg::CH_STX;
                        for (int i = 0; i < remote_cmd_pkg::SIND_LEN; i++) begin
                           rep_q[8*(i+1) +: 8] <= digit({2'b00, screen.sind[2*i +: 2]});
                        end
                        rep_q[8*11 +: 16] <= {remote_cmd_pkg::CH_LF, remote_cmd_pkg::CH_CR};
                        rep_len_q <= LW'(13);
                     end
                  end
                  remote_cmd_pkg::CLS_FUNC: begin
                     if (num_q <= remote_cmd_pkg::FN_PRINT) begin
                        rep_q[7:0] <= remote_cmd_pkg::CH_ACK;
                        action.ref_toggle <= (num_q == remote_cmd_pkg::FN_REF);
                        action.series_start <= (num_q == remote_cmd_pkg::FN_SERIES);
                        action.print <= (num_q == remote_cmd_pkg::FN_PRINT);
                        measure_req <= (num_q == remote_cmd_pkg::FN_PRINT);
                     end
                  end
                  remote_cmd_pkg::CLS_SPECIAL: begin
                     if (num_q <= remote_cmd_pkg::SF_RELEASE) begin
                        rep_q[7:0] <= remote_cmd_pkg::CH_ACK;
                        action.unit_reset <= (num_q == remote_cmd_pkg::SF_RESET);
                        if (num_q == remote_cmd_pkg::SF_LOCK) begin
                           keypad_locked <= 1'b1;
                        end else begin
                           keypad_locked <= 1'b0;
                        end
                     end
                  end
                  default: begin
                  end
               endcase
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Transmitter: XOFF takes priority over reply bytes; XON waits until the reply bytes are sent.
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         tx <= '0;
         rep_idx_q <= '0;
      end else begin
         if (tx.valid && tx_ready) begin
            tx.valid <= 1'b0;
         end else if (!tx.valid && tx_ready) begin
            if (xoff_pend_q) begin
               tx <= '{valid: 1'b1, data: remote_cmd_pkg::CH_XOFF};
            end else if (st_q == P_SEND && rep_idx_q != rep_len_q) begin
               tx <= '{valid: 1'b1, data: rep_q[8*rep_idx_q +: 8]};
               rep_idx_q <= rep_idx_q + 1'b1;
            end else if (xon_pend_q) begin
               tx <= '{valid: 1'b1, data: remote_cmd_pkg::CH_XON};
            end
         end
         if (st_q == P_EXEC) begin
            rep_idx_q <= '0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Checks.
   property p_key_ack_first;
      @(posedge ref_clk) disable iff (!rst_n)
      $rose(action.key_valid) |-> !post_key_q && !tx.valid;
   endproperty
   a_key_ack_first: assert property (p_key_ack_first) else $error("key action before ack sent");

   property p_no_overflow;
      @(posedge ref_clk) disable iff (!rst_n)
      cnt_q <= FULL;
   endproperty
   a_no_overflow: assert property (p_no_overflow) else $error("buffer count beyond depth");

   property p_xoff_on_full;
      @(posedge ref_clk) disable iff (!rst_n)
      (cnt_q == FULL && !stopped_q) |=> stopped_q;
   endproperty
   a_xoff_on_full: assert property (p_xoff_on_full) else $error("full buffer without xoff");

   property p_exec_from_cr;
      @(posedge ref_clk) disable iff (!rst_n)
      st_q == P_EXEC |-> $past(st_q) == P_CR && $past(cur) == remote_cmd_pkg::CH_CR;
   endproperty
   a_exec_from_cr: assert property (p_exec_from_cr) else $error("executed without carriage return");

   property p_lock_held;
      @(posedge ref_clk) disable iff (!rst_n)
      $rose(keypad_locked) |-> $past(num_q) == remote_cmd_pkg::SF_LOCK;
   endproperty
   a_lock_held: assert property (p_lock_held) else $error("keypad locked without lock command");

   property p_print_measure;
      @(posedge ref_clk) disable iff (!rst_n)
      action.print |-> measure_req;
   endproperty
   a_print_measure: assert property (p_print_measure) else $error("print without measurement output");

   property p_err_only_shown;
      @(posedge ref_clk) disable iff (!rst_n)
      (st_q == P_EXEC && cls_q == remote_cmd_pkg::CLS_SCREEN && num_q == remote_cmd_pkg::SCR_ERROR
       && !screen.err_shown) |=> rep_q[7:0] == remote_cmd_pkg::CH_NAK;
   endproperty
   a_err_only_shown: assert property (p_err_only_shown) else $error("error text sent while none shown");

   property p_bad_nak;
      @(posedge ref_clk) disable iff (!rst_n)
      (st_q == P_EXEC && bad_q) |=> rep_len_q == LW'(1) && rep_q[7:0] == remote_cmd_pkg::CH_NAK;
   endproperty
   a_bad_nak: assert property (p_bad_nak) else $error("invalid command not refused");
endmodule

/* verif/remote_host_model.sv */
// Purpose: Host terminal that sends command bytes and collects the replies.
// Assumes: Bytes move at the falling edge; one byte per cycle at most.
// Notes: Flow-control bytes are counted and kept out of the reply queue.
`timescale 1ns/100ps
module remote_host_model (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rst_n,
   // Byte link
   input wire remote_cmd_pkg::byte_t tx,
   output remote_cmd_pkg::byte_t rx,
   output logic tx_ready,
   // Pacing
   input wire logic slow
);
   logic [7:0] got[$];
   logic [7:0] last_byte = 8'h00;
   logic paused = 1'b0;
   logic [1:0] pace = 2'h0;
   int n_xoff = 0;
   int n_xon = 0;

   initial begin
      rx = '0;
      tx_ready = 1'b0;
   end

   ////////////////////////////////////////////////////////////
   always @(posedge ref_clk) begin
      if (rst_n && tx.valid && tx_ready) begin
         if (tx.data === remote_cmd_pkg::CH_XOFF) begin
            paused = 1'b1;
            n_xoff++;
         end else if (tx.data === remote_cmd_pkg::CH_XON) begin
            paused = 1'b0;
            n_xon++;
         end else begin
            last_byte = tx.data;
            got.push_back(tx.data);
         end
      end
   end

   // A slow host takes one byte in four cycles.
   always @(negedge ref_clk) begin
      pace <= pace + 2'h1;
      tx_ready <= !slow || pace == 2'h0;
   end

   task automatic send_byte(input logic [7:0] b);
      @(negedge ref_clk);
      while (paused) begin
         rx <= {1'b0, ~rx.data};
         @(negedge ref_clk);
      end
      rx <= {1'b1, b};
   endtask

   task automatic idle();
      @(negedge ref_clk);
      rx <= {1'b0, ~rx.data};
   endtask
endmodule

/* verif/remote_key_command_interpreter_test.sv */
// Purpose: Self-checking bench for the remote key command interpreter.
// Assumes: Screen text fields hold random digit characters; bar and indicator fields hold small random values.
// Notes: Expected replies are built from the screen snapshot.
`timescale 1ns/100ps
module remote_key_command_interpreter_test;
   logic ref_clk = 1'b0;
   logic rst_n = 1'b0;
   logic slow = 1'b0;
   remote_cmd_pkg::byte_t rx;
   remote_cmd_pkg::byte_t tx;
   logic tx_ready;
   logic keypad_locked;
   logic measure_req;
   remote_cmd_pkg::screen_t screen = '0;
   remote_cmd_pkg::action_t action;
   int seed = 82103;
   int num_errors = 0;
   int checks_done = 0;
   int cycles = 0;
   int n_ref = 0, n_ser = 0, n_prt = 0, n_meas = 0, n_urst = 0;
   logic [7:0] exp[$];
   logic [4:0] keys[$];
   int scr[8] = '{0, 100, 200, 301, 400, 800, 900, 500};
   int bad[3] = '{10, 111, 9999};
   logic [7:0] junk[21] = '{8'h54, 8'h30, 8'h30, 8'h30, 8'h35, 8'h0D, 8'h1B, 8'h54, 8'h30, 8'h30, 8'h30,
      8'h35, 8'h58, 8'h1B, 8'h1B, 8'h54, 8'h30, 8'h30, 8'h30, 8'h35, 8'h0D};

   remote_key_command_interpreter u_remote_key_command_interpreter (.ref_clk(ref_clk), .rst_n(rst_n),
      .rx(rx), .tx_ready(tx_ready), .tx(tx), .screen(screen), .action(action),
      .keypad_locked(keypad_locked), .measure_req(measure_req));
   remote_host_model u_remote_host_model (.ref_clk(ref_clk), .rst_n(rst_n), .tx(tx), .rx(rx),
      .tx_ready(tx_ready), .slow(slow));

   always #2.5 ref_clk = ~ref_clk;

   ////////////////////////////////////////////////////////////
   task automatic give_verdict();
      $display("checks %0d errors %0d", checks_done, num_errors);
      if (num_errors == 0 && checks_done > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] want);
      checks_done++;
      if (got !== want) begin
         num_errors++;
         $display("wrong value at %0t: got %0h expected %0h", $time, got, want);
      end
   endtask

   always @(negedge ref_clk) begin
      cycles++;
      if (cycles == 60000) begin
         num_errors++;
         give_verdict();
      end
      if (rst_n === 1'b1) begin
         if (action.key_valid === 1'b1) begin
            keys.push_back(action.key_code);
            chk(u_remote_host_model.last_byte, remote_cmd_pkg::CH_ACK);
         end
         n_ref += int'(action.ref_toggle === 1'b1);
         n_ser += int'(action.series_start === 1'b1);
         n_prt += int'(action.print === 1'b1);
         n_urst += int'(action.unit_reset === 1'b1);
         n_meas += int'(measure_req === 1'b1);
      end
   end

   function automatic logic [7:0] rdig();
      return remote_cmd_pkg::CH_ZERO + 8'($unsigned($random(seed)) % 10);
   endfunction

   task automatic rand_screen(input int len, input logic shown);
      for (int i = 0; i < 35; i++) begin
         screen.err_text[i * 8 +: 8] = rdig();
         if (i < 30) screen.ident[i * 8 +: 8] = rdig();
         if (i < 13) screen.disp_pos[i * 8 +: 8] = rdig();
         if (i < 10) screen.act_pos[i * 8 +: 8] = rdig();
         if (i < 10) screen.soft_id[i * 8 +: 8] = rdig();
         if (i < 10) screen.sind[i * 2 +: 2] = 2'($unsigned($random(seed)) % 3);
         if (i < 8) screen.sbar[i * 4 +: 4] = 4'($unsigned($random(seed)) % 5);
      end
      screen.disp_len = 4'(len);
      screen.err_shown = shown;
   endtask

   task automatic cmd(input logic [7:0] cls, input int code);
      u_remote_host_model.send_byte(remote_cmd_pkg::CH_ESC);
      u_remote_host_model.send_byte(cls);
      for (int d = 1000; d >= 1; d /= 10) u_remote_host_model.send_byte(8'h30 + 8'((code / d) % 10));
      u_remote_host_model.send_byte(remote_cmd_pkg::CH_CR);
      u_remote_host_model.idle();
   endtask

   // Field byte 0 sits at the top of the field and goes out first.
   task automatic put_text(input logic [279:0] v, input int n, input int cnt);
      for (int i = 0; i < cnt; i++) exp.push_back(v[(n - 1 - i) * 8 +: 8]);
      exp.push_back(remote_cmd_pkg::CH_CR);
      exp.push_back(remote_cmd_pkg::CH_LF);
   endtask

   task automatic expect_screen(input int c);
      logic [79:0] si;
      logic [63:0] sb;
      for (int j = 0; j < 10; j++) si[(9 - j) * 8 +: 8] = 8'h30 + 8'(screen.sind[j * 2 +: 2]);
      for (int j = 0; j < 8; j++) sb[(7 - j) * 8 +: 8] = 8'h30 + 8'(screen.sbar[j * 4 +: 4]);
      if (!(c inside {0, 100, 200, 400, 800, 900} || (c == 301 && screen.err_shown)))
         exp.push_back(remote_cmd_pkg::CH_NAK);
      else begin
         exp.push_back(remote_cmd_pkg::CH_STX);
         case (c)
            0: for (int l = 2; l >= 0; l--) put_text(280'(screen.ident >> (l * 80)), 10, 10);
            100: put_text(280'(screen.disp_pos), 13, int'(screen.disp_len));
            200: put_text(280'(screen.act_pos), 10, 10);
            301: put_text(screen.err_text, 35, 35);
            400: put_text(280'(screen.soft_id), 10, 10);
            800: put_text(280'(sb), 8, 8);
            default: put_text(280'(si), 10, 10);
         endcase
      end
   endtask

   task automatic settle();
      int quiet;
      int waited;
      quiet = 0;
      waited = 0;
      while (quiet < 40 && waited < 6000) begin
         @(negedge ref_clk);
         waited++;
         quiet = (tx.valid === 1'b1) ? 0 : quiet + 1;
      end
      chk(u_remote_host_model.got.size(), exp.size());
      for (int i = 0; i < exp.size() && i < u_remote_host_model.got.size(); i++)
         chk(u_remote_host_model.got[i], exp[i]);
      u_remote_host_model.got.delete();
      exp.delete();
   endtask

   ////////////////////////////////////////////////////////////
   initial begin
      int n;
      repeat (20) @(negedge ref_clk);
      rst_n = 1'b1;
      @(negedge ref_clk);
      chk({tx.valid, action, keypad_locked, measure_req}, 32'h0);
      for (int k = 0; k < 21; k++) begin
         cmd(remote_cmd_pkg::CLS_KEY, k < 10 ? k : k + 90);
         exp.push_back(remote_cmd_pkg::CH_ACK);
         settle();
         chk(keys.size(), 1);
         chk(keys[0], k);
         keys.delete();
      end
      foreach (bad[i]) begin
         cmd(remote_cmd_pkg::CLS_KEY, bad[i]);
         exp.push_back(remote_cmd_pkg::CH_NAK);
         settle();
         chk(keys.size(), 0);
      end
      for (int rep = 0; rep < 2; rep++) begin
         slow = rep[0];
         rand_screen(rep ? 13 : 10, rep[0]);
         foreach (scr[i]) begin
            cmd(remote_cmd_pkg::CLS_SCREEN, scr[i]);
            expect_screen(scr[i]);
            settle();
         end
      end
      for (int f = 0; f < 4; f++) begin
         cmd(remote_cmd_pkg::CLS_FUNC, f);
         exp.push_back(f < 3 ? remote_cmd_pkg::CH_ACK : remote_cmd_pkg::CH_NAK);
         settle();
      end
      chk(n_ref, 1);
      chk(n_ser, 1);
      chk(n_prt, 1);
      chk(n_meas, 1);
      cmd(remote_cmd_pkg::CLS_SPECIAL, 1);
      cmd(remote_cmd_pkg::CLS_KEY, 3);
      exp = '{remote_cmd_pkg::CH_ACK, remote_cmd_pkg::CH_ACK};
      settle();
      chk({keypad_locked, 3'h0, keys.size() == 1, 3'h0, keys[0]}, 32'h1103);
      keys.delete();
      for (int s = 2; s >= 0; s--) begin
         cmd(remote_cmd_pkg::CLS_SPECIAL, s == 1 ? 3 : s);
         exp.push_back(s == 1 ? remote_cmd_pkg::CH_NAK : remote_cmd_pkg::CH_ACK);
         settle();
      end
      chk(keypad_locked, 0);
      chk(n_urst, 1);
      foreach (junk[i]) u_remote_host_model.send_byte(junk[i]);
      u_remote_host_model.idle();
      exp.push_back(remote_cmd_pkg::CH_ACK);
      settle();
      chk(keys.size(), 1);
      chk(keys[0], 5);
      slow = 1'b1;
      for (int c = 0; c < 14; c++) begin
         cmd(remote_cmd_pkg::CLS_SCREEN, 0);
         expect_screen(0);
      end
      n = 0;
      while (u_remote_host_model.n_xoff == 0 && n < 300) begin
         u_remote_host_model.send_byte(8'h20);
         n++;
      end
      u_remote_host_model.idle();
      settle();
      chk(u_remote_host_model.n_xoff, 1);
      chk(u_remote_host_model.n_xon, 1);
      give_verdict();
   end
endmodule
